// file: pkg/cs_pkg.sv
package cs_pkg;

	// ----------------------------------------
	// Timebase and phase limits
	// ----------------------------------------
	// Tick rates of the two capacitor-set oscillators; the rate is arbitrary
	localparam int MAIN_TICK_HZ = 2240;
	localparam int CC_TICK_HZ = 2240;
	// Phase limits as printed: tenths of minutes for prequal, minutes else
	localparam int PREQ_TIME_DMIN = 75;
	localparam int FULL_TIME_MIN = 90;
	localparam int TOPOFF_TIME_MIN = 45;
	localparam int FAST_TIME_MIN = 90;
	// Temperature sampling rate in hundredths of a hertz
	localparam int TEMP_RATE_CHZ = 112;
	// Length of the charge halt around each temperature reading, in ticks
	localparam int MEAS_TICKS = 4;

	localparam int TMR_W = 24;
	localparam int PREQ_TICKS = PREQ_TIME_DMIN * 6 * MAIN_TICK_HZ;
	localparam int FULL_TICKS = FULL_TIME_MIN * 60 * MAIN_TICK_HZ;
	localparam int TOPOFF_TICKS = TOPOFF_TIME_MIN * 60 * MAIN_TICK_HZ;
	localparam int FAST_TICKS = FAST_TIME_MIN * 60 * CC_TICK_HZ;
	localparam int TEMP_TICKS = MAIN_TICK_HZ * 100 / TEMP_RATE_CHZ;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_PHASE_CNT = 4'h8;
	localparam logic [3:0] REG_FAST_CNT = 4'hc;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam int CTRL_HOLD_BIT = 0;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_PAUSE_BIT = 8;
	localparam int STAT_HOT_BIT = 9;
	localparam int STAT_COLD_BIT = 10;
	localparam int STAT_CELL_LSB = 11;
	localparam int STAT_MEAS_BIT = 13;
	localparam int STAT_SHUTDOWN_N_BIT = 14;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// Charge states
	// ----------------------------------------
	typedef enum logic [6:0] {
		CS_RESET = 7'h01,
		CS_PREQ = 7'h02,
		CS_FAST = 7'h04,
		CS_FULL = 7'h08,
		CS_TOPOFF = 7'h10,
		CS_DONE = 7'h20,
		CS_FAULT = 7'h40
	} cs_state_e;

	localparam logic [1:0] CELL_ONE = 2'h1;
	localparam logic [1:0] CELL_TWO = 2'h2;
	localparam logic [1:0] CELL_THREE = 2'h3;

endpackage

// file: rtl/cs_sync.sv
`timescale 1ns/1ps
module cs_sync
	import cs_pkg::*;
#(
	parameter int W = 1
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	// Only the second stage is visible outside
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			meta_ff <= '0;
			q_ff <= '0;
		end
		else
		begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end

	assign q = q_ff;

endmodule

// file: rtl/cs_tick_timer.sv
`timescale 1ns/1ps
module cs_tick_timer
	import cs_pkg::*;
#(
	parameter int W = 24
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Control
	input wire logic clear,
	input wire logic run,
	input wire logic [W-1:0] terminal,
	// State
	output logic [W-1:0] count,
	output logic expired
);

	logic [W-1:0] count_ff;

	// Holding the count while run is low is what freezes a phase
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			count_ff <= '0;
		else if (clear)
			count_ff <= '0;
		else if (run && !expired)
			count_ff <= count_ff + 1'b1;
	end

	assign count = count_ff;
	assign expired = (count_ff >= terminal);

endmodule

// file: rtl/cs_supervisor.sv
// Overview of operation
// RQ1 - Main ticks time prequal, full, top-off; cc ticks fast
// RQ2 - Limits 7.5, 90, 45 and 90 minutes
// RQ3 - Fast indicator asserted only in fast charge
// RQ4 - Full indicator asserted in constant-voltage full charge
// RQ5 - Fault stops charging, asserts fault indicator
// RQ6 - Fault left only by power or shutdown
// RQ7 - Inhibit charging when battery too hot or cold
// RQ8 - Hot and cold checks alternate on one input
// RQ9 - Sample temperature at 1.12Hz, halting charge briefly
// RQ10 - Out of limits pauses charge, freezes timer
// RQ11 - Shutdown stops charge, switch off, divider off
// RQ12 - Shutdown releases all three indicators
// RQ13 - Leaving shutdown restarts from reset, timers cleared
// RQ14 - Supply within 100mV of battery stops charger
// RQ15 - Strap low/float/high gives one/two/three cells
// RQ16 - Indicators per state, else all released
// RQ17 - Fault on prequal/fast expiry or hot at reset
// RQ18 - Prequal at tenth current until above undervoltage
// RQ19 - Done recharges below threshold; full ends on expiry/current
// RQ20 - Timers count oscillator ticks to fixed terminals
`timescale 1ns/1ps
module cs_supervisor
	import cs_pkg::*;
#(
	parameter logic [TMR_W-1:0] PREQ_LIMIT = TMR_W'(PREQ_TICKS),
	parameter logic [TMR_W-1:0] FULL_LIMIT = TMR_W'(FULL_TICKS),
	parameter logic [TMR_W-1:0] TOPOFF_LIMIT = TMR_W'(TOPOFF_TICKS),
	parameter logic [TMR_W-1:0] FAST_LIMIT = TMR_W'(FAST_TICKS),
	parameter logic [TMR_W-1:0] TEMP_LIMIT = TMR_W'(TEMP_TICKS)
)
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// AXI4-Lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins and analog comparator results
	input wire logic shutdown_n,
	input wire logic main_timebase_tick,
	input wire logic cc_timebase_tick,
	input wire logic battery_sense_above_uv,
	input wire logic battery_sense_at_reg,
	input wire logic battery_sense_below_recharge,
	input wire logic battery_sense_over_volt,
	input wire logic charge_current_low,
	input wire logic supply_dropout,
	input wire logic bias_ok,
	input wire logic temp_out_of_limit,
	input wire logic cell_strap_low,
	input wire logic cell_strap_high,
	// Open-drain indicators
	output logic fast_phase_indicator_n_out,
	output logic fast_phase_indicator_n_oe,
	output logic cv_phase_indicator_n_out,
	output logic cv_phase_indicator_n_oe,
	output logic fault_indicator_n_out,
	output logic fault_indicator_n_oe,
	// Power stage and sense control
	output logic charge_enable,
	output logic precharge_mode,
	output logic cv_mode,
	output logic divider_connect,
	output logic temp_sense_hot,
	output logic [1:0] cell_count
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam int NSYNC = 13;
	logic [NSYNC-1:0] pins_s;
	logic shutdown_n_n_s, main_tick_s, cc_tick_s, above_uv_s, at_reg_s;
	logic below_rech_s, over_v_s, cur_low_s, dropout_s, bias_ok_s;
	logic temp_bad_s, strap_low_s, strap_high_s;

	cs_sync #(.W(NSYNC)) u_sync (
		.clock(clock),
		.nrst(nrst),
		.d({shutdown_n, main_timebase_tick, cc_timebase_tick,
			battery_sense_above_uv, battery_sense_at_reg, battery_sense_below_recharge,
			battery_sense_over_volt, charge_current_low, supply_dropout,
			bias_ok, temp_out_of_limit, cell_strap_low,
			cell_strap_high}),
		.q(pins_s)
	);

	assign {shutdown_n_n_s, main_tick_s, cc_tick_s, above_uv_s, at_reg_s,
		below_rech_s, over_v_s, cur_low_s, dropout_s, bias_ok_s,
		temp_bad_s, strap_low_s, strap_high_s} = pins_s;

	// ----------------------------------------
	// Oscillator tick edges
	// ----------------------------------------
	logic main_tick_d_ff, cc_tick_d_ff;
	logic main_tick, cc_tick;
	logic in_shutdown_n;

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			main_tick_d_ff <= 1'b0;
			cc_tick_d_ff <= 1'b0;
		end
		else
		begin
			main_tick_d_ff <= main_tick_s;
			cc_tick_d_ff <= cc_tick_s;
		end
	end

	assign main_tick = main_tick_s && !main_tick_d_ff; // [RQ20]
	assign cc_tick = cc_tick_s && !cc_tick_d_ff; // [RQ20]
	assign in_shutdown_n = !shutdown_n_n_s;

	// ----------------------------------------
	// Control register and shared state
	// ----------------------------------------
	logic [31:0] ctrl_ff;
	logic host_hold;
	cs_state_e state_ff, nxt_state;
	logic temp_hot_ff, temp_cold_ff, meas_ff, sense_hot_ff;
	logic [1:0] cell_ff;
	logic temp_ok, paused, charging_state;

	assign host_hold = ctrl_ff[CTRL_HOLD_BIT];
	assign temp_ok = !temp_hot_ff && !temp_cold_ff;
	assign paused = !temp_ok || host_hold; // [RQ7]
	assign charging_state = (state_ff == CS_PREQ) || (state_ff == CS_FAST)
		|| (state_ff == CS_FULL) || (state_ff == CS_TOPOFF);

	// ----------------------------------------
	// Phase timers
	// ----------------------------------------
	logic [TMR_W-1:0] phase_cnt, fast_cnt, temp_cnt;
	logic [TMR_W-1:0] phase_limit, temp_term;
	logic phase_exp, fast_exp, temp_exp;
	logic phase_run, phase_clr, fast_run, fast_clr, temp_clr;

	// One main-timebase counter serves all three of its phases [RQ1]
	always_comb
	begin
		case (state_ff)
			CS_PREQ: phase_limit = PREQ_LIMIT; // [RQ2]
			CS_FULL: phase_limit = FULL_LIMIT; // [RQ2]
			CS_TOPOFF: phase_limit = TOPOFF_LIMIT; // [RQ2]
			default: phase_limit = PREQ_LIMIT;
		endcase
	end

	// A frozen timer keeps its count until charging resumes [RQ10]
	assign phase_run = main_tick && !paused && ((state_ff == CS_PREQ)
		|| (state_ff == CS_FULL) || (state_ff == CS_TOPOFF)); // [RQ1]
	assign phase_clr = in_shutdown_n || (nxt_state != state_ff); // [RQ13]
	assign fast_run = cc_tick && !paused && (state_ff == CS_FAST); // [RQ1]
	assign fast_clr = in_shutdown_n || (state_ff != CS_FAST); // [RQ13]

	cs_tick_timer #(.W(TMR_W)) u_phase_tmr (
		.clock(clock),
		.nrst(nrst),
		.clear(phase_clr),
		.run(phase_run),
		.terminal(phase_limit),
		.count(phase_cnt),
		.expired(phase_exp)
	);

	cs_tick_timer #(.W(TMR_W)) u_fast_tmr (
		.clock(clock),
		.nrst(nrst),
		.clear(fast_clr),
		.run(fast_run),
		.terminal(FAST_LIMIT), // [RQ2]
		.count(fast_cnt),
		.expired(fast_exp)
	);

	// ----------------------------------------
	// Temperature qualification
	// ----------------------------------------
	// The same counter times the idle gap and the short measuring window
	assign temp_term = meas_ff ? TMR_W'(MEAS_TICKS)
		: TEMP_LIMIT - TMR_W'(MEAS_TICKS); // [RQ9]
	assign temp_clr = in_shutdown_n || temp_exp;

	cs_tick_timer #(.W(TMR_W)) u_temp_tmr (
		.clock(clock),
		.nrst(nrst),
		.clear(temp_clr),
		.run(main_tick),
		.terminal(temp_term),
		.count(temp_cnt),
		.expired(temp_exp)
	);

	// Reading taken at the end of the window, when the sense has settled
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			meas_ff <= 1'b0;
			sense_hot_ff <= 1'b1;
			temp_hot_ff <= 1'b0;
			temp_cold_ff <= 1'b0;
		end
		else if (in_shutdown_n)
		begin
			meas_ff <= 1'b0;
			sense_hot_ff <= 1'b1;
		end
		else if (temp_exp)
		begin
			meas_ff <= !meas_ff; // [RQ9]
			if (meas_ff)
			begin
				sense_hot_ff <= !sense_hot_ff; // [RQ8]
				if (sense_hot_ff)
					temp_hot_ff <= temp_bad_s; // [RQ8]
				else
					temp_cold_ff <= temp_bad_s; // [RQ8]
			end
		end
	end

	// ----------------------------------------
	// Charge state machine
	// ----------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			CS_RESET:
			begin
				if (temp_hot_ff)
					nxt_state = CS_FAULT; // [RQ17]
				else if (bias_ok_s && !dropout_s && !over_v_s)
					nxt_state = CS_PREQ;
			end
			CS_PREQ:
			begin
				if (phase_exp)
					nxt_state = CS_FAULT; // [RQ17]
				else if (above_uv_s && !paused)
					nxt_state = CS_FAST; // [RQ18]
			end
			CS_FAST:
			begin
				if (fast_exp)
					nxt_state = CS_FAULT; // [RQ17]
				else if (at_reg_s && !paused)
					nxt_state = CS_FULL;
			end
			CS_FULL:
			begin
				if (phase_exp || (cur_low_s && !paused))
					nxt_state = CS_TOPOFF; // [RQ19]
			end
			CS_TOPOFF:
			begin
				if (phase_exp)
					nxt_state = CS_DONE;
			end
			CS_DONE:
			begin
				if (below_rech_s)
					nxt_state = CS_RESET; // [RQ19]
			end
			CS_FAULT: nxt_state = CS_FAULT; // [RQ6]
			default: nxt_state = CS_RESET;
		endcase
		// Loss of headroom or overvoltage restarts, but a fault stays
		if ((dropout_s || over_v_s) && (state_ff != CS_FAULT))
			nxt_state = CS_RESET; // [RQ14]
	end

	// Shutdown is the only way out of fault short of power removal
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			state_ff <= CS_RESET;
		else if (in_shutdown_n)
			state_ff <= CS_RESET; // [RQ6] [RQ13]
		else
			state_ff <= nxt_state;
	end

	// Strap read while idle in reset, after the pins are synchronised
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			cell_ff <= CELL_TWO;
		else if (state_ff == CS_RESET)
		begin
			if (strap_low_s)
				cell_ff <= CELL_ONE; // [RQ15]
			else if (strap_high_s)
				cell_ff <= CELL_THREE; // [RQ15]
			else
				cell_ff <= CELL_TWO; // [RQ15]
		end
	end

	// ----------------------------------------
	// Power stage and indicator outputs
	// ----------------------------------------
	logic chg_en_ff, pre_ff, cv_ff, div_ff;
	logic fast_oe_ff, full_oe_ff, fault_oe_ff;

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			chg_en_ff <= 1'b0;
			pre_ff <= 1'b0;
			cv_ff <= 1'b0;
			div_ff <= 1'b0;
		end
		else
		begin
			chg_en_ff <= charging_state && !paused && !meas_ff
				&& !in_shutdown_n && !dropout_s; // [RQ5] [RQ9] [RQ11] [RQ14]
			pre_ff <= (state_ff == CS_PREQ); // [RQ18]
			cv_ff <= (state_ff == CS_FULL) || (state_ff == CS_TOPOFF);
			div_ff <= !in_shutdown_n; // [RQ11]
		end
	end

	// Pause leaves the indicators as they were, since the state holds
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			fast_oe_ff <= 1'b0;
			full_oe_ff <= 1'b0;
			fault_oe_ff <= 1'b0;
		end
		else
		begin
			fast_oe_ff <= !in_shutdown_n && (state_ff == CS_FAST); // [RQ3] [RQ16]
			full_oe_ff <= !in_shutdown_n && (state_ff == CS_FULL); // [RQ4] [RQ16]
			fault_oe_ff <= !in_shutdown_n && (state_ff == CS_FAULT); // [RQ5]
		end
	end

	// ----------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------
	logic awready_ff, wready_ff, bvalid_ff, aw_held_ff, w_held_ff;
	logic [1:0] bresp_ff;
	logic [ADDR_W-1:0] awaddr_ff, wr_addr;
	logic [31:0] wdata_ff, wr_data;
	logic [3:0] wstrb_ff, wr_strb;
	logic aw_take, w_take, wr_fire;
	logic nxt_aw_held, nxt_w_held, nxt_bvalid;

	assign aw_take = s_axi_awvalid && awready_ff;
	assign w_take = s_axi_wvalid && wready_ff;
	assign wr_fire = (aw_held_ff || aw_take) && (w_held_ff || w_take);
	assign wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
	assign wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
	assign wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;
	assign nxt_aw_held = (aw_held_ff || aw_take) && !wr_fire;
	assign nxt_w_held = (w_held_ff || w_take) && !wr_fire;
	assign nxt_bvalid = wr_fire || (bvalid_ff && !s_axi_bready);

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
		end
		else
		begin
			aw_held_ff <= nxt_aw_held;
			w_held_ff <= nxt_w_held;
			awready_ff <= !nxt_aw_held && !nxt_bvalid;
			wready_ff <= !nxt_w_held && !nxt_bvalid;
			bvalid_ff <= nxt_bvalid;
			if (aw_take)
				awaddr_ff <= s_axi_awaddr;
			if (w_take)
			begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_fire)
				bresp_ff <= (wr_addr == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// Only the low byte of the control word is writable; other words answer with an error
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			ctrl_ff <= CTRL_RST;
		else if (wr_fire && (wr_addr == REG_CTRL) && wr_strb[0])
			ctrl_ff[7:0] <= wr_data[7:0];
	end

	// ----------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------
	logic arready_ff, rvalid_ff, ar_take, nxt_rvalid;
	logic [31:0] rdata_ff, status_word;
	logic [1:0] rresp_ff;

	assign ar_take = s_axi_arvalid && arready_ff;
	assign nxt_rvalid = ar_take || (rvalid_ff && !s_axi_rready);

	always_comb
	begin
		status_word = '0;
		status_word[STAT_STATE_LSB +: 7] = state_ff;
		status_word[STAT_PAUSE_BIT] = paused && charging_state;
		status_word[STAT_HOT_BIT] = temp_hot_ff;
		status_word[STAT_COLD_BIT] = temp_cold_ff;
		status_word[STAT_CELL_LSB +: 2] = cell_ff;
		status_word[STAT_MEAS_BIT] = meas_ff;
		status_word[STAT_SHUTDOWN_N_BIT] = in_shutdown_n;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= RESP_OKAY;
		end
		else
		begin
			arready_ff <= !nxt_rvalid;
			rvalid_ff <= nxt_rvalid;
			if (ar_take)
			begin
				rresp_ff <= RESP_OKAY;
				case (s_axi_araddr)
					REG_CTRL: rdata_ff <= ctrl_ff;
					REG_STATUS: rdata_ff <= status_word;
					REG_PHASE_CNT: rdata_ff <= 32'(phase_cnt);
					REG_FAST_CNT: rdata_ff <= 32'(fast_cnt);
					default:
					begin
						rdata_ff <= '0;
						rresp_ff <= RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Output assignments
	// ----------------------------------------
	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	// Open-drain pins only ever pull low; release is oe low [RQ12]
	assign fast_phase_indicator_n_out = 1'b0;
	assign fast_phase_indicator_n_oe = fast_oe_ff;
	assign cv_phase_indicator_n_out = 1'b0;
	assign cv_phase_indicator_n_oe = full_oe_ff;
	assign fault_indicator_n_out = 1'b0;
	assign fault_indicator_n_oe = fault_oe_ff;
	assign charge_enable = chg_en_ff;
	assign precharge_mode = pre_ff;
	assign cv_mode = cv_ff;
	assign divider_connect = div_ff;
	assign temp_sense_hot = sense_hot_ff;
	assign cell_count = cell_ff;

endmodule

// file: verif/cs_supervisor_assertions.sv
`timescale 1ns/1ps
module cs_supervisor_assertions
	import cs_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Pins
	input wire logic shutdown_n,
	input wire logic supply_dropout,
	input wire logic fast_phase_indicator_n_oe,
	input wire logic cv_phase_indicator_n_oe,
	input wire logic fault_indicator_n_oe,
	input wire logic charge_enable,
	input wire logic precharge_mode,
	input wire logic cv_mode,
	input wire logic divider_connect,
	input wire logic temp_sense_hot
);
	// ------------------------------
	// Properties
	// ------------------------------
	default clocking cs_cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	// Six samples cover the pin synchroniser, state and output stages
	property p_shutdown_n_led;
		!shutdown_n [*6] |-> !fast_phase_indicator_n_oe &&
			!cv_phase_indicator_n_oe && !fault_indicator_n_oe;
	endproperty
	a_shutdown_n_led: assert property (p_shutdown_n_led)
		else $error("indicator driven in shutdown");

	property p_shutdown_n_off;
		!shutdown_n [*6] |-> !charge_enable && !divider_connect;
	endproperty
	a_shutdown_n_off: assert property (p_shutdown_n_off)
		else $error("charge or divider on in shutdown");

	property p_drop;
		supply_dropout [*6] |-> !charge_enable;
	endproperty
	a_drop: assert property (p_drop)
		else $error("charging during supply dropout");

	property p_fast;
		fast_phase_indicator_n_oe |-> !cv_mode && !precharge_mode;
	endproperty
	a_fast: assert property (p_fast)
		else $error("fast indicator outside constant current");

	property p_cv;
		cv_phase_indicator_n_oe |-> cv_mode && !precharge_mode;
	endproperty
	a_cv: assert property (p_cv)
		else $error("full indicator outside voltage mode");

	property p_fault_off;
		fault_indicator_n_oe |-> !charge_enable &&
			!fast_phase_indicator_n_oe && !cv_phase_indicator_n_oe;
	endproperty
	a_fault_off: assert property (p_fault_off)
		else $error("charging or other indicator in fault");

	// Only shutdown or reset may drop a latched fault
	property p_fault_hold;
		shutdown_n [*5] ##0 fault_indicator_n_oe |=> fault_indicator_n_oe;
	endproperty
	a_fault_hold: assert property (p_fault_hold)
		else $error("fault left without shutdown");

	// Each check lasts a whole temperature period, far above eight clocks
	property p_sense_alt;
		$changed(temp_sense_hot) |=>
			($stable(temp_sense_hot) || !divider_connect) [*8];
	endproperty
	a_sense_alt: assert property (p_sense_alt)
		else $error("temperature sense toggled too fast");
endmodule

bind cs_supervisor cs_supervisor_assertions cs_supervisor_assertions_i (
	.clock, .nrst, .shutdown_n, .supply_dropout, .fast_phase_indicator_n_oe,
	.cv_phase_indicator_n_oe, .fault_indicator_n_oe, .charge_enable,
	.precharge_mode, .cv_mode, .divider_connect, .temp_sense_hot);

// file: verif/cs_battery_model.sv
`timescale 1ns/1ps
module cs_battery_model
	import cs_pkg::*;
#(
	parameter int MAIN_HALF = 4,
	parameter int CC_HALF = 5
)
(
	// Clock
	input wire logic clock,
	// Thermistor condition
	input wire logic too_hot,
	input wire logic too_cold,
	// From supervisor
	input wire logic temp_sense_hot,
	input wire logic [2:0] led_oe,
	// To supervisor
	output logic main_tick,
	output logic cc_tick,
	output logic temp_out_of_limit,
	output logic [2:0] led_n
);
	int main_cnt = 0;
	int cc_cnt = 0;

	// ------------------------------
	// Oscillators and thermistor
	// ------------------------------
	// Ramps run free, also in reset, as capacitor oscillators do
	always_ff @(posedge clock)
	begin
		main_cnt <= (main_cnt + 1) % (2 * MAIN_HALF);
		cc_cnt <= (cc_cnt + 1) % (2 * CC_HALF);
		main_tick <= main_cnt < MAIN_HALF;
		cc_tick <= cc_cnt < CC_HALF;
		temp_out_of_limit <= temp_sense_hot ? too_hot : too_cold;
	end

	// LEDs hang on pull-ups, so a released pin reads high
	assign led_n = ~led_oe;
endmodule

// file: verif/test_charge_sequence_supervisor.sv
`timescale 1ns/1ps
module test_charge_sequence_supervisor
	import cs_pkg::*;
;
	localparam int PREQ = 20;
	logic clock = 1'b0, nrst = 1'b0, shutdown_n = 1'b1, bias_ok = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic battery_sense_above_uv = 1'b0, battery_sense_at_reg = 1'b0;
	logic battery_sense_below_recharge = 1'b0, battery_sense_over_volt = 1'b0;
	logic charge_current_low = 1'b0, supply_dropout = 1'b0;
	logic cell_strap_low = 1'b0, cell_strap_high = 1'b0;
	logic too_hot = 1'b0, too_cold = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, main_timebase_tick, cc_timebase_tick;
	logic [1:0] s_axi_bresp, s_axi_rresp, cell_count;
	logic fast_phase_indicator_n_oe, cv_phase_indicator_n_oe;
	logic fault_indicator_n_oe, charge_enable, precharge_mode, cv_mode;
	logic divider_connect, temp_sense_hot, temp_out_of_limit;
	logic [2:0] led_n, led_out;
	int n_mismatch = 0, checks_done = 0, cyc = 0;

	always #10 clock = ~clock;

	cs_supervisor #(.PREQ_LIMIT(TMR_W'(PREQ)), .FULL_LIMIT(24'h28),
		.TOPOFF_LIMIT(24'h1e), .FAST_LIMIT(24'hc8), .TEMP_LIMIT(24'hc))
	cs_supervisor_i (
		.clock, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .shutdown_n, .main_timebase_tick,
		.cc_timebase_tick, .battery_sense_above_uv, .battery_sense_at_reg,
		.battery_sense_below_recharge, .battery_sense_over_volt, .charge_current_low,
		.supply_dropout, .bias_ok, .temp_out_of_limit, .cell_strap_low,
		.cell_strap_high, .fast_phase_indicator_n_out(led_out[2]),
		.fast_phase_indicator_n_oe, .cv_phase_indicator_n_out(led_out[1]),
		.cv_phase_indicator_n_oe, .fault_indicator_n_out(led_out[0]),
		.fault_indicator_n_oe, .charge_enable, .precharge_mode, .cv_mode,
		.divider_connect, .temp_sense_hot, .cell_count);

	cs_battery_model cs_battery_model_i (
		.clock, .too_hot, .too_cold, .temp_sense_hot,
		.led_oe({fast_phase_indicator_n_oe, cv_phase_indicator_n_oe,
			fault_indicator_n_oe}),
		.main_tick(main_timebase_tick), .cc_tick(cc_timebase_tick),
		.temp_out_of_limit, .led_n);

	// ------------------------------
	// Tasks
	// ------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] s, e);
		checks_done++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h got %h", n, e, s);
		end
	endtask

	// Leading edge keeps a back-to-back call from driving twice at once
	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever
		begin
			@(posedge clock);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
			begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever
		begin
			@(posedge clock);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
			begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic wait_st(input logic [6:0] s, input int max);
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < max; i++)
		begin
			rd(REG_STATUS, d, r);
			if (d[6:0] === s)
				break;
		end
		chk("state", d[6:0], s);
	endtask

	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_mismatch++;
			stop_test();
		end
	end

	// ------------------------------
	// Sequence
	// ------------------------------
	initial
	begin
		logic [31:0] d, e;
		logic [1:0] r;
		int t0;
		void'($urandom(32'h121731a3));
		repeat (4) @(posedge clock);
		nrst <= 1'b1;
		repeat (10) @(posedge clock);
		for (int i = 0; i < 3; i++)
		begin
			cell_strap_low <= (i == 0);
			cell_strap_high <= (i == 2);
			repeat (8) @(posedge clock);
			chk("cells", cell_count, i + 1);
		end
		wait_st(CS_RESET, 2);
		rd(4'h2, d, r);
		chk("bad_rresp", r, RESP_SLVERR);
		wr(REG_STATUS, 32'h1, r);
		chk("ro_bresp", r, RESP_SLVERR);
		repeat (3)
		begin
			e = $urandom;
			wr(REG_CTRL, e, r);
			rd(REG_CTRL, d, r);
			chk("ctrl", d, e & 32'hff);
		end
		wr(REG_CTRL, 32'h0, r);
		// Dead battery runs the prequal timer out
		bias_ok <= 1'b1;
		wait_st(CS_PREQ, 20);
		chk("prech", {precharge_mode, led_n}, 4'hf);
		t0 = cyc;
		wait_st(CS_FAULT, 200);
		t0 = cyc - t0;
		chk("preq_t", t0 >= PREQ * 8 - 16 && t0 <= PREQ * 16 + 40, 1);
		chk("fault", {charge_enable, led_n, led_out}, 7'h30);
		battery_sense_above_uv <= 1'b1;
		repeat (60) @(posedge clock);
		chk("latched", led_n, 3'h6);
		shutdown_n <= 1'b0;
		repeat (8) @(posedge clock);
		chk("shutdown_n", {charge_enable, divider_connect, led_n}, 5'h7);
		shutdown_n <= 1'b1;
		wait_st(CS_FAST, 40);
		chk("fast", {cv_mode, precharge_mode, led_n}, 5'h3);
		// Cold battery mid fast charge
		too_cold <= 1'b1;
		repeat (250) @(posedge clock);
		rd(REG_STATUS, d, r);
		chk("paused", {d[8], charge_enable}, 2'h2);
		rd(REG_FAST_CNT, e, r);
		repeat (100) @(posedge clock);
		rd(REG_FAST_CNT, d, r);
		chk("frozen", d, e);
		too_cold <= 1'b0;
		repeat (250) @(posedge clock);
		rd(REG_FAST_CNT, d, r);
		chk("resumed", d > e, 1);
		do rd(REG_STATUS, d, r); while (d[13] !== 1'b1);
		chk("meas", charge_enable, 0);
		battery_sense_at_reg <= 1'b1;
		wait_st(CS_FULL, 40);
		chk("full", {cv_mode, led_n}, 4'hd);
		charge_current_low <= 1'b1;
		wait_st(CS_TOPOFF, 40);
		chk("topoff", led_n, 3'h7);
		wait_st(CS_DONE, 300);
		battery_sense_at_reg <= 1'b0;
		charge_current_low <= 1'b0;
		battery_sense_below_recharge <= 1'b1;
		wait_st(CS_FAST, 40);
		battery_sense_below_recharge <= 1'b0;
		supply_dropout <= 1'b1;
		wait_st(CS_RESET, 10);
		chk("drop", charge_enable, 0);
		// Hot battery while held in reset
		supply_dropout <= 1'b0;
		bias_ok <= 1'b0;
		too_hot <= 1'b1;
		wait_st(CS_FAULT, 100);
		stop_test();
	end
endmodule
